//--- rim_pkg.sv
// Shared constants and types for the rack I/O word mapper
package rim_pkg;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 7;
  localparam int FB_WORDS_SMALL = 16;
  localparam int FB_WORDS_LARGE = 64;
  // Word addresses on the mapper link
  localparam logic [6:0] A_FB_HEAD = 7'h00;
  localparam logic [6:0] A_DOUT = 7'h40;
  localparam logic [6:0] A_DIN = 7'h41;
  localparam logic [6:0] A_AO_CFG = 7'h42;
  localparam logic [6:0] A_AO_CH1 = 7'h43;
  localparam logic [6:0] A_AO_CH2 = 7'h44;
  // Fieldbus status and command fields
  localparam int FB_SUM_LSB = 8;
  localparam int FB_STAT_W = 5;
  localparam int CMD_ALARM_BIT = 1;
  localparam int CMD_START_BIT = 2;
  localparam int CMD_QUIT_BIT = 3;
  localparam logic [7:0] CMD_GET_CONFIG = 8'h28;
  // Analog output configuration fields
  localparam logic [7:0] AO_RES_SIGNED15 = 8'h00;
  localparam logic [7:0] AO_RES_12BIT = 8'h06;
  localparam int AO_HOLD1_BIT = 8;
  localparam int AO_HOLD2_BIT = 9;
  localparam logic signed [15:0] AO_MAX_S15 = 16'sh7FF0;
  localparam logic signed [15:0] AO_MAX_12 = 16'sh0FFF;
  localparam logic signed [15:0] AO_MIN_12 = 16'sh0000;
  // Controller Avalon register byte addresses
  localparam logic [4:0] R_CTRL = 5'h00;
  localparam logic [4:0] R_ADDR = 5'h04;
  localparam logic [4:0] R_WDATA = 5'h08;
  localparam logic [4:0] R_RDATA = 5'h0C;
  localparam logic [4:0] R_STATUS = 5'h10;
  localparam logic [4:0] R_MASK = 5'h14;
  localparam logic [4:0] R_CMD = 5'h18;
  // Controller control and status bits
  localparam int CTRL_GO = 0;
  localparam int CTRL_WRITE = 1;
  localparam int CTRL_PRIMARY = 2;
  localparam int ST_DONE = 0;
  localparam int ST_REFUSED = 1;
  localparam int ST_W = 2;
  typedef enum logic [2:0] {
    RIM_OUT16 = 3'h0,
    RIM_OUT4 = 3'h1,
    RIM_OUT8 = 3'h2,
    RIM_IN8_OUT4 = 3'h3,
    RIM_IN8_OUT8 = 3'h4,
    RIM_IN4_OUT4 = 3'h5
  } rim_dio_kind_t;
endpackage

//--- rim_if.sv
// Word link between the network controller and the rack mapper
`timescale 1ns/1ps
interface rim_if;
  logic req;
  logic we;
  logic [6:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic ack;
  modport mapper (input req, input we, input addr, input wdata, output rdata, output ack);
  modport controller (output req, output we, output addr, output wdata, input rdata, input ack);
endinterface

//--- rim_mapper.sv
// Rack-side word mapper: fieldbus, discrete and analog output images
`timescale 1ns/1ps
// Contract
// - Switches pick 0, 16 or 64 fieldbus words
// - Controller uses 64 words only primary rack
// - Status word: checksum high, bitmap low
// - Controller echoes last read checksum
// - Command bits: stop, start, quit, config
// - Data words follow status and command
// - Sixteen outputs: output 1 from bit 15
// - Four outputs from bits 3-0
// - Eight outputs from bits 7-0
// - Eight in, four out packing
// - Eight in, eight out packing
// - Monitored four in, four out packing
// - Analog output uses three words
// - Config low byte selects resolution
// - Bits 8, 9 choose hold or default
// - Controller keeps channel values in range
// - Halt holds or defaults each channel
module rim_mapper (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  rim_if.mapper link,
  input rim_pkg::rim_dio_kind_t dio_kind,
  input wire logic [7:0] din_pins,
  output logic [15:0] dout_pins,
  input wire logic word_count_switch_a,
  input wire logic word_count_switch_b,
  input wire logic [7:0] fb_checksum,
  input wire logic [4:0] fb_status,
  input wire logic fb_in_we,
  input wire logic [5:0] fb_in_idx,
  input wire logic [15:0] fb_in_data,
  input wire logic [5:0] fb_out_idx,
  output logic [15:0] fb_out_data,
  output logic [6:0] fb_words,
  output logic fb_alarm_stop,
  output logic fb_start_cycle,
  output logic fb_quit_error,
  output logic fb_get_config,
  input wire logic halted,
  input wire logic [15:0] ao_default1,
  input wire logic [15:0] ao_default2,
  output logic [15:0] ao_out1,
  output logic [15:0] ao_out2,
  output logic ao_res_12bit,
  output logic ao_res_bad
);
  logic [7:0] din_meta;
  logic [7:0] din_s;
  logic [1:0] sw_meta;
  logic [1:0] sw_s;
  logic halt_meta;
  logic halt_s;
  logic [15:0] fb_in_mem [1:63];
  logic [15:0] fb_out_mem [1:63];
  logic [15:0] dout_word;
  logic [15:0] ao_cfg;
  logic [15:0] ao_ch1;
  logic [15:0] ao_ch2;
  logic [4:0] out_pts;
  logic [4:0] in_pts;
  logic [15:0] din_word;
  logic [15:0] next_rdata;
  logic wr;
  logic rd;
  logic fb_hit;

  // Reverse the low points so point 1 sits in the top used bit
  function automatic logic [15:0] rim_pack(input logic [15:0] src, input logic [4:0] pts);
    logic [15:0] res;
    res = '0;
    for (int i = 0; i < 16; i++)
    begin
      if (i < int'(pts))
      begin
        res[i] = src[int'(pts) - 1 - i];
      end
    end
    return res;
  endfunction

  // Pin synchronisers
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      {din_s, din_meta, sw_s, sw_meta, halt_s, halt_meta} <= '0;
    end
    else if (ce)
    begin
      {din_meta, sw_meta, halt_meta} <=
        {din_pins, word_count_switch_b, word_count_switch_a, halted};
      {din_s, sw_s, halt_s} <= {din_meta, sw_meta, halt_meta};
    end
  end

  assign fb_words = (sw_s == 2'b11) ? 7'(rim_pkg::FB_WORDS_LARGE) :
    (sw_s == 2'b01) ? 7'(rim_pkg::FB_WORDS_SMALL) : 7'h00;

  // Points per module kind
  always_comb
  begin
    unique case (dio_kind)
      rim_pkg::RIM_OUT16: {out_pts, in_pts} = {5'h10, 5'h00};
      rim_pkg::RIM_OUT4: {out_pts, in_pts} = {5'h04, 5'h00};
      rim_pkg::RIM_OUT8: {out_pts, in_pts} = {5'h08, 5'h00};
      rim_pkg::RIM_IN8_OUT4: {out_pts, in_pts} = {5'h04, 5'h08};
      rim_pkg::RIM_IN8_OUT8: {out_pts, in_pts} = {5'h08, 5'h08};
      rim_pkg::RIM_IN4_OUT4: {out_pts, in_pts} = {5'h04, 5'h04};
      default: {out_pts, in_pts} = {5'h00, 5'h00};
    endcase
  end

  assign din_word = rim_pack({8'h00, din_s}, in_pts);

  assign wr = link.req & link.we & ~link.ack;
  assign rd = link.req & ~link.we & ~link.ack;
  assign fb_hit = (link.addr != rim_pkg::A_FB_HEAD) && (link.addr < fb_words);

  // Link handshake
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      link.ack <= 1'b0;
    end
    else if (ce)
    begin
      link.ack <= link.req & ~link.ack;
    end
  end

  // Read mux
  always_comb
  begin
    unique case (link.addr)
      rim_pkg::A_FB_HEAD: next_rdata = {fb_checksum, 3'b000, fb_status};
      rim_pkg::A_DOUT: next_rdata = dout_word;
      rim_pkg::A_DIN: next_rdata = din_word;
      rim_pkg::A_AO_CFG: next_rdata = ao_cfg;
      rim_pkg::A_AO_CH1: next_rdata = ao_ch1;
      rim_pkg::A_AO_CH2: next_rdata = ao_ch2;
      default: next_rdata = fb_hit ? fb_in_mem[6'(link.addr)] : 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      link.rdata <= '0;
    end
    else if (ce && rd)
    begin
      link.rdata <= next_rdata;
    end
  end

  // Fieldbus image memories
  always_ff @(posedge core_clk)
  begin
    if (ce && fb_in_we && fb_in_idx != 6'h00)
    begin
      fb_in_mem[fb_in_idx] <= fb_in_data;
    end
    if (ce && wr && fb_hit)
    begin
      fb_out_mem[6'(link.addr)] <= link.wdata;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      fb_out_data <= '0;
    end
    else if (ce)
    begin
      fb_out_data <= (fb_out_idx != 6'h00 && 7'(fb_out_idx) < fb_words) ?
        fb_out_mem[fb_out_idx] : 16'h0000;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      {fb_get_config, fb_quit_error, fb_start_cycle, fb_alarm_stop} <= '0;
    end
    else if (ce)
    begin
      {fb_get_config, fb_quit_error, fb_start_cycle, fb_alarm_stop} <= '0;
      if (wr && link.addr == rim_pkg::A_FB_HEAD && fb_words != 7'h00)
      begin
        if (link.wdata[7:0] == rim_pkg::CMD_GET_CONFIG)
          fb_get_config <= 1'b1;
        else
          {fb_quit_error, fb_start_cycle, fb_alarm_stop} <= {link.wdata[rim_pkg::CMD_QUIT_BIT],
            link.wdata[rim_pkg::CMD_START_BIT], link.wdata[rim_pkg::CMD_ALARM_BIT]};
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      {dout_word, ao_cfg, ao_ch1, ao_ch2} <= '0;
    end
    else if (ce && wr)
    begin
      if (link.addr == rim_pkg::A_DOUT)
        dout_word <= link.wdata;
      if (link.addr == rim_pkg::A_AO_CFG)
        ao_cfg <= link.wdata;
      if (link.addr == rim_pkg::A_AO_CH1)
        ao_ch1 <= link.wdata;
      if (link.addr == rim_pkg::A_AO_CH2)
        ao_ch2 <= link.wdata;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      dout_pins <= '0;
    end
    else if (ce)
    begin
      dout_pins <= rim_pack(dout_word, out_pts);
    end
  end

  assign ao_res_12bit = ao_cfg[7:0] == rim_pkg::AO_RES_12BIT;
  assign ao_res_bad = ao_cfg[7:0] != rim_pkg::AO_RES_12BIT &&
    ao_cfg[7:0] != rim_pkg::AO_RES_SIGNED15;

  // halt holds or defaults per channel
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      {ao_out1, ao_out2} <= '0;
    end
    else if (ce)
    begin
      if (!halt_s)
        {ao_out1, ao_out2} <= {ao_ch1, ao_ch2};
      if (halt_s && !ao_cfg[rim_pkg::AO_HOLD1_BIT])
        ao_out1 <= ao_default1;
      if (halt_s && !ao_cfg[rim_pkg::AO_HOLD2_BIT])
        ao_out2 <= ao_default2;
    end
  end
endmodule

//--- rim_controller.sv
// Network-side controller: Avalon registers to mapper word link
`timescale 1ns/1ps
module rim_controller (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  rim_if.controller link,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq
);
  typedef enum logic [1:0] {RIM_IDLE, RIM_BUSY} rim_state_t;
  rim_state_t state;
  logic av_ack;
  logic primary;
  logic [6:0] tgt_addr;
  logic [15:0] tgt_wdata;
  logic [15:0] rd_word;
  logic [7:0] last_sum;
  logic res12;
  logic [rim_pkg::ST_W-1:0] status;
  logic [rim_pkg::ST_W-1:0] mask;
  logic av_wr;
  logic start;
  logic is_cmd;
  logic refuse;
  logic ev_done;
  logic ev_ref;
  logic [6:0] next_addr;
  logic [15:0] next_wdata;
  logic next_we;
  logic signed [15:0] wv;
  logic primary_now;

  assign avs_waitrequest = (avs_read | avs_write) & ~av_ack;
  assign av_wr = avs_write & av_ack & ce;
  assign is_cmd = av_wr && avs_address == rim_pkg::R_CMD;
  assign start = is_cmd || (av_wr && avs_address == rim_pkg::R_CTRL &&
    avs_writedata[rim_pkg::CTRL_GO]);
  assign irq = |(status & mask);

  // Request building
  always_comb
  begin
    wv = signed'(tgt_wdata);
    next_addr = tgt_addr;
    next_we = avs_writedata[rim_pkg::CTRL_WRITE];
    next_wdata = tgt_wdata;
    if (is_cmd)
    begin
      next_addr = rim_pkg::A_FB_HEAD;
      next_we = 1'b1;
      next_wdata = {last_sum, avs_writedata[7:0]};
    end
    else if (tgt_addr == rim_pkg::A_AO_CH1 || tgt_addr == rim_pkg::A_AO_CH2)
    begin
      if (res12)
      begin
        if (wv < rim_pkg::AO_MIN_12)
        begin
          next_wdata = rim_pkg::AO_MIN_12;
        end
        else if (wv > rim_pkg::AO_MAX_12)
        begin
          next_wdata = rim_pkg::AO_MAX_12;
        end
      end
      else if (wv > rim_pkg::AO_MAX_S15)
      begin
        next_wdata = rim_pkg::AO_MAX_S15;
      end
    end
  end

  // large fieldbus image only in primary rack
  assign primary_now = (av_wr && avs_address == rim_pkg::R_CTRL) ?
    avs_writedata[rim_pkg::CTRL_PRIMARY] : primary;
  assign refuse = !is_cmd && !primary_now && next_addr >= 7'(rim_pkg::FB_WORDS_SMALL) &&
    next_addr < 7'(rim_pkg::FB_WORDS_LARGE);

  // Avalon answer one cycle after request
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      av_ack <= 1'b0;
    end
    else if (ce)
    begin
      av_ack <= (avs_read | avs_write) & ~av_ack;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      avs_readdata <= '0;
    end
    else if (ce && avs_read && !av_ack)
    begin
      unique case (avs_address)
        rim_pkg::R_CTRL: avs_readdata <= {29'h0, primary, 1'b0, state == RIM_BUSY};
        rim_pkg::R_ADDR: avs_readdata <= {25'h0, tgt_addr};
        rim_pkg::R_WDATA: avs_readdata <= {16'h0, tgt_wdata};
        rim_pkg::R_RDATA: avs_readdata <= {16'h0, rd_word};
        rim_pkg::R_STATUS: avs_readdata <= {30'h0, status};
        rim_pkg::R_MASK: avs_readdata <= {30'h0, mask};
        default: avs_readdata <= '0;
      endcase
    end
  end

  // Software registers
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      primary <= 1'b0;
      tgt_addr <= '0;
      tgt_wdata <= '0;
      mask <= '0;
    end
    else if (av_wr)
    begin
      if (avs_address == rim_pkg::R_CTRL)
      begin
        primary <= avs_writedata[rim_pkg::CTRL_PRIMARY];
      end
      if (avs_address == rim_pkg::R_ADDR)
      begin
        tgt_addr <= avs_writedata[6:0];
      end
      if (avs_address == rim_pkg::R_WDATA)
      begin
        tgt_wdata <= avs_writedata[15:0];
      end
      if (avs_address == rim_pkg::R_MASK)
      begin
        mask <= avs_writedata[rim_pkg::ST_W-1:0];
      end
    end
  end

  // Link transaction engine
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state <= RIM_IDLE;
      link.req <= 1'b0;
      link.we <= 1'b0;
      link.addr <= '0;
      link.wdata <= '0;
    end
    else if (ce)
    begin
      unique case (state)
        RIM_IDLE:
        begin
          if (start && !refuse)
          begin
            link.req <= 1'b1;
            link.we <= next_we;
            link.addr <= next_addr;
            link.wdata <= next_wdata;
            state <= RIM_BUSY;
          end
        end
        RIM_BUSY:
        begin
          if (link.ack)
          begin
            link.req <= 1'b0;
            state <= RIM_IDLE;
          end
        end
      endcase
    end
  end

  assign ev_done = ce && state == RIM_BUSY && link.ack;
  assign ev_ref = start && refuse && state == RIM_IDLE;

  // Read capture, checksum and resolution tracking
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      rd_word <= '0;
      last_sum <= '0;
      res12 <= 1'b0;
    end
    else if (ev_done)
    begin
      if (!link.we)
      begin
        rd_word <= link.rdata;
        if (link.addr == rim_pkg::A_FB_HEAD)
        begin
          last_sum <= link.rdata[15:rim_pkg::FB_SUM_LSB];
        end
      end
      else if (link.addr == rim_pkg::A_AO_CFG)
      begin
        res12 <= link.wdata[7:0] == rim_pkg::AO_RES_12BIT;
      end
    end
  end

  // Sticky status, set wins over clear
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      status <= '0;
    end
    else if (ce)
    begin
      status <= (status & ~((av_wr && avs_address == rim_pkg::R_STATUS) ?
        avs_writedata[rim_pkg::ST_W-1:0] : 2'b00)) | {ev_ref, ev_done};
    end
  end
endmodule

//--- rim_assertions.sv
// Link handshake and word layout checks for the rack mapper
`timescale 1ns/1ps
module rim_assertions (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic req,
  input wire logic we,
  input wire logic [6:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic ack
);
  logic [7:0] last_sum;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence taken_s;
    req && !ack;
  endsequence
  sequence rd_ack_s(logic [6:0] a);
    ack && !we && addr == a;
  endsequence
  // Checksum last read from the status word
  always_ff @(posedge core_clk)
  begin
    if (reset)
      last_sum <= 8'h00;
    else if (ack && !we && addr == rim_pkg::A_FB_HEAD)
      last_sum <= rdata[15:8];
  end
  ack_after_req_a:
    assert property (taken_s |=> ack) else $error("ack missing after request");
  ack_pulse_a:
    assert property (ack |=> !ack) else $error("ack longer than one cycle");
  req_release_a:
    assert property (ack |=> !req) else $error("request not released after ack");
  req_hold_a:
    assert property (taken_s |=> req && $stable(addr) && $stable(we) && $stable(wdata))
      else $error("request changed before ack");
  status_gap_a:
    assert property (rd_ack_s(rim_pkg::A_FB_HEAD) |-> rdata[7:5] == 3'h0)
      else $error("status bits 7-5 not zero");
  din_upper_a:
    assert property (rd_ack_s(rim_pkg::A_DIN) |-> rdata[15:8] == 8'h00)
      else $error("input word high byte not zero");
  echo_sum_a:
    assert property (ack && we && addr == rim_pkg::A_FB_HEAD |-> wdata[15:8] == last_sum)
      else $error("command checksum differs from last read");
  unmapped_zero_a:
    assert property (ack && !we && addr > rim_pkg::A_AO_CH2 |-> rdata == 16'h0000)
      else $error("unmapped word read not zero");
  rdata_stands_a:
    assert property (!$stable(rdata) |-> ack && !we) else $error("read word changed without read");
endmodule

//--- testbench.sv
// Self-checking bench: controller and mapper joined over the word link
`timescale 1ns/1ps
`define CHK(n, e, g) \
  begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %s exp %h got %h", n, (e), (g)); end end
module testbench;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, irq;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, got;
  rim_pkg::rim_dio_kind_t dio_kind = rim_pkg::RIM_OUT16;
  logic [7:0] din_pins = 8'h00, fb_checksum = 8'h00;
  logic word_count_switch_a = 1'b0, word_count_switch_b = 1'b0, fb_in_we = 1'b0, halted = 1'b0;
  logic [4:0] fb_status = 5'h00;
  logic [5:0] fb_in_idx = 6'h00, fb_out_idx = 6'h00;
  logic [15:0] fb_in_data = 16'h0, ao_default1 = 16'h0, ao_default2 = 16'h0;
  logic [15:0] dout_pins, fb_out_data, ao_out1, ao_out2;
  logic [6:0] fb_words;
  logic fb_alarm_stop, fb_start_cycle, fb_quit_error, fb_get_config, ao_res_12bit, ao_res_bad;
  logic [3:0] seen = 4'h0;
  logic seen_clr = 1'b0;
  logic [31:0] seed = 32'h19;
  logic [31:0] exp_q[$];
  int err_total = 0;
  int total_checks = 0;
  rim_if link();
  rim_controller i_rim_controller (.core_clk(core_clk), .reset(reset), .ce(ce), .link(link),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));
  rim_mapper i_rim_mapper (.core_clk(core_clk), .reset(reset), .ce(ce), .link(link),
    .dio_kind(dio_kind), .din_pins(din_pins), .dout_pins(dout_pins),
    .word_count_switch_a(word_count_switch_a), .word_count_switch_b(word_count_switch_b),
    .fb_checksum(fb_checksum), .fb_status(fb_status), .fb_in_we(fb_in_we),
    .fb_in_idx(fb_in_idx), .fb_in_data(fb_in_data), .fb_out_idx(fb_out_idx),
    .fb_out_data(fb_out_data), .fb_words(fb_words), .fb_alarm_stop(fb_alarm_stop),
    .fb_start_cycle(fb_start_cycle), .fb_quit_error(fb_quit_error),
    .fb_get_config(fb_get_config), .halted(halted), .ao_default1(ao_default1),
    .ao_default2(ao_default2), .ao_out1(ao_out1), .ao_out2(ao_out2),
    .ao_res_12bit(ao_res_12bit), .ao_res_bad(ao_res_bad));
  rim_assertions i_rim_assertions (.core_clk(core_clk), .reset(reset), .req(link.req),
    .we(link.we), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack));
  initial
  begin
    forever #4 core_clk = ~core_clk;
  end
  // Compare each taken read against the oldest note
  always @(posedge core_clk)
  begin
    if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0)
    begin
      got = exp_q.pop_front();
      `CHK("avs_readdata", got, avs_readdata)
    end
  end
  always @(posedge core_clk)
    seen <= seen_clr ? 4'h0 : seen | {fb_get_config, fb_quit_error, fb_start_cycle, fb_alarm_stop};
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  function automatic logic [15:0] rev(input logic [15:0] v, input int n);
    logic [15:0] r = 16'h0;
    for (int i = 0; i < n; i++)
      r[i] = v[n - 1 - i];
    return r;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic av(input logic [4:0] a, input logic w, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge core_clk);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= d;
    do
    begin
      @(posedge core_clk);
    end
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic poll(input logic clr, output logic [1:0] st);
    logic [31:0] q = 32'h0;
    while (q[1:0] == 2'b00)
      av(rim_pkg::R_STATUS, 1'b0, 32'h0, q);
    st = q[1:0];
    if (clr)
      av(rim_pkg::R_STATUS, 1'b1, 32'h3, q);
  endtask
  task automatic xfer(input logic w, input logic [6:0] a, input logic [15:0] d, input logic p,
                      output logic [1:0] st);
    logic [31:0] q;
    av(rim_pkg::R_ADDR, 1'b1, {25'h0, a}, q);
    av(rim_pkg::R_WDATA, 1'b1, {16'h0, d}, q);
    av(rim_pkg::R_CTRL, 1'b1, {29'h0, p, w, 1'b1}, q);
    poll(1'b1, st);
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [15:0] e, input logic p);
    logic [1:0] st;
    logic [31:0] q;
    xfer(1'b0, a, 16'h0, p, st);
    exp_q.push_back({16'h0, e});
    av(rim_pkg::R_RDATA, 1'b0, 32'h0, q);
  endtask
  task automatic end_of_test();
    if (err_total == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    end_of_test();
  end
  initial
  begin
    logic [15:0] w;
    logic [1:0] st;
    logic [31:0] q;
    int nw[6] = '{16, 4, 8, 4, 8, 4};
    tick(20);
    reset <= 1'b0;
    // Discrete packing for every module kind
    for (int k = 0; k < 6; k++)
    begin
      w = rnd();
      dio_kind <= rim_pkg::rim_dio_kind_t'(k[2:0]);
      din_pins <= w[7:0];
      xfer(1'b1, rim_pkg::A_DOUT, w, 1'b0, st);
      tick(4);
      `CHK("dout_pins", rev(w, nw[k]), dout_pins)
      if (k >= 3)
        rd_chk(rim_pkg::A_DIN, rev({8'h00, w[7:0]}, (k == 5) ? 4 : 8), 1'b0);
    end
    // Fieldbus sizes, data words and refusal
    word_count_switch_a <= 1'b1;
    word_count_switch_b <= 1'b1;
    tick(4);
    `CHK("fb_words", 7'h40, fb_words)
    w = rnd();
    fb_in_idx <= 6'h28;
    fb_in_data <= w;
    fb_in_we <= 1'b1;
    tick(1);
    fb_in_we <= 1'b0;
    rd_chk(7'h28, w, 1'b1);
    xfer(1'b0, 7'h28, 16'h0, 1'b0, st);
    `CHK("refused", 1'b1, st[1])
    w = rnd();
    xfer(1'b1, 7'h28, w, 1'b1, st);
    fb_out_idx <= 6'h28;
    tick(2);
    `CHK("fb_out_data", w, fb_out_data)
    word_count_switch_b <= 1'b0;
    tick(4);
    `CHK("fb_words", 7'h10, fb_words)
    `CHK("fb_out_data", 16'h0, fb_out_data)
    rd_chk(7'h28, 16'h0, 1'b1);
    w = rnd();
    fb_checksum <= w[15:8];
    fb_status <= w[4:0];
    tick(1);
    rd_chk(rim_pkg::A_FB_HEAD, {w[15:8], 3'h0, w[4:0]}, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      seen_clr <= 1'b1;
      tick(1);
      seen_clr <= 1'b0;
      av(rim_pkg::R_CMD, 1'b1, (i < 3) ? (32'h2 << i) : 32'h28, q);
      poll(1'b1, st);
      tick(3);
      `CHK("fb_commands", 4'h1 << i, seen)
    end
    word_count_switch_a <= 1'b0;
    tick(4);
    `CHK("fb_words", 7'h00, fb_words)
    // Analog resolution, clamping and halt behaviour
    ao_default1 <= rnd();
    ao_default2 <= rnd();
    w = rnd() & 16'h0FFF;
    xfer(1'b1, rim_pkg::A_AO_CFG, 16'h0106, 1'b0, st);
    `CHK("ao_res_12bit", 1'b1, ao_res_12bit)
    xfer(1'b1, rim_pkg::A_AO_CH1, 16'h1388, 1'b0, st);
    xfer(1'b1, rim_pkg::A_AO_CH2, w, 1'b0, st);
    tick(2);
    `CHK("ao_out1", 16'h0FFF, ao_out1)
    `CHK("ao_out2", w, ao_out2)
    halted <= 1'b1;
    tick(5);
    `CHK("ao_out1", 16'h0FFF, ao_out1)
    `CHK("ao_out2", ao_default2, ao_out2)
    halted <= 1'b0;
    tick(4);
    xfer(1'b1, rim_pkg::A_AO_CFG, 16'h0200, 1'b0, st);
    `CHK("ao_res_12bit", 1'b0, ao_res_12bit)
    xfer(1'b1, rim_pkg::A_AO_CH1, 16'h8000, 1'b0, st);
    xfer(1'b1, rim_pkg::A_AO_CH2, 16'h7FFF, 1'b0, st);
    tick(2);
    `CHK("ao_out1", 16'h8000, ao_out1)
    `CHK("ao_out2", 16'h7FF0, ao_out2)
    halted <= 1'b1;
    tick(5);
    `CHK("ao_out1", ao_default1, ao_out1)
    `CHK("ao_out2", 16'h7FF0, ao_out2)
    halted <= 1'b0;
    xfer(1'b1, rim_pkg::A_AO_CFG, 16'h0003, 1'b0, st);
    `CHK("ao_res_bad", 1'b1, ao_res_bad)
    // Unmapped places and the interrupt
    rd_chk(7'h50, 16'h0, 1'b0);
    exp_q.push_back(32'h0);
    av(5'h1C, 1'b0, 32'h0, q);
    av(rim_pkg::R_MASK, 1'b1, 32'h0, q);
    av(rim_pkg::R_CTRL, 1'b1, 32'h1, q);
    poll(1'b0, st);
    tick(1);
    `CHK("irq", 1'b0, irq)
    av(rim_pkg::R_MASK, 1'b1, 32'h1, q);
    tick(1);
    `CHK("irq", 1'b1, irq)
    av(rim_pkg::R_STATUS, 1'b1, 32'h1, q);
    tick(1);
    `CHK("irq", 1'b0, irq)
    // Clock enable low freezes the switch synchronisers
    ce <= 1'b0;
    word_count_switch_a <= 1'b1;
    word_count_switch_b <= 1'b1;
    tick(4);
    `CHK("fb_words", 7'h00, fb_words)
    ce <= 1'b1;
    tick(4);
    `CHK("fb_words", 7'h40, fb_words)
    end_of_test();
  end
endmodule
